// ### design/headphone_dc_offset_servo.v
`timescale 1ns/1ns
`include "servo_regs.vh"

module headphone_dc_offset_servo #(
  parameter integer MEASURE_CYCLES = `MEASURE_CYCLES,
  parameter integer LOAD_CYCLES = `LOAD_CYCLES,
  parameter integer ADDR_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Avalon-MM slave
  input wire [ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Measured offsets from the converter front end
  input wire [7:0] measuredOffsetLeft,
  input wire [7:0] measuredOffsetRight,
  // Corrections applied to the headphone outputs
  output wire [7:0] leftHeadphoneCorrection,
  output wire [7:0] rightHeadphoneCorrection,
  // Events
  output reg irq,
  output reg [1:0] gpioDone
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge for 16-bit registers in the low half of the bus
  function [15:0] mergeBytes;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0] be;
    begin
      mergeBytes[7:0] = be[0] ? newVal[7:0] : oldVal[7:0];
      mergeBytes[15:8] = be[1] ? newVal[15:8] : oldVal[15:8];
    end
  endfunction

  function hitIndex;
    input [ADDR_W-1:0] addr;
    input [9:0] idx;
    begin
      hitIndex = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    end
  endfunction

  function [1:0] laneLow2;
    input [15:0] data;
    input lane;
    begin
      laneLow2 = data[1:0] & {lane, lane};
    end
  endfunction

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // One wait cycle: read data is captured while waitrequest is high,
  // so it stands at the edge where the master sees waitrequest low.
  reg ack_reg;
  wire request;
  wire writeTaken;
  wire [15:0] wdata;

  assign request = read | write;
  assign waitrequest = request & ~ack_reg;
  assign writeTaken = write & ack_reg;
  assign wdata = writedata[15:0];

  always @(posedge clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
    end else begin
      // Drops after one cycle, so a held request is answered every other cycle
      ack_reg <= request & ~ack_reg;
    end
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire selTrig;
  wire selTimer;
  wire selReadback;
  wire selOffset;
  wire selStatus;
  wire selMask;
  wire selGpio;

  // Word index only; the two low address bits are ignored
  assign selTrig = hitIndex(address, `IDX_TRIG_ENA);
  assign selTimer = hitIndex(address, `IDX_TIMER);
  assign selReadback = hitIndex(address, `IDX_READBACK);
  assign selOffset = hitIndex(address, `IDX_OFFSET);
  assign selStatus = hitIndex(address, `IDX_INT_STATUS);
  assign selMask = hitIndex(address, `IDX_INT_MASK);
  assign selGpio = hitIndex(address, `IDX_GPIO_SEL);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg [1:0] enable_reg;
  reg [3:0] timer_reg;
  reg [15:0] loadWords_reg;
  reg [1:0] intMask_reg;
  reg [1:0] gpioSel_reg;
  reg [15:0] trigMerged;
  reg [15:0] timerMerged;
  reg [15:0] offsetMerged;

  // Unwritten lanes keep their old contents; intMask_reg and gpioSel_reg load 0 if lane 0 is unwritten
  always @* begin
    trigMerged = mergeBytes({10'h000, 4'h0, enable_reg}, wdata, byteenable[1:0]);
    timerMerged = mergeBytes({12'h000, timer_reg}, wdata, byteenable[1:0]);
    offsetMerged = mergeBytes(loadWords_reg, wdata, byteenable[1:0]);
  end

  always @(posedge clk) begin
    if (srst) begin
      enable_reg <= `RST_ENA;
      timer_reg <= `RST_TIMER;
      loadWords_reg <= {`RST_OFFSET, `RST_OFFSET};
      // Interrupts masked and pins quiet until software opts in
      intMask_reg <= `RST_MASK;
      gpioSel_reg <= `RST_GPIO_SEL;
    end else if (writeTaken) begin
      if (selTrig) begin
        enable_reg[0] <= trigMerged[`BIT_ENA_LEFT];
        enable_reg[1] <= trigMerged[`BIT_ENA_RIGHT];
      end
      if (selTimer) begin
        timer_reg <= timerMerged[3:0];
      end
      if (selOffset) begin
        loadWords_reg <= offsetMerged;
      end
      if (selMask) begin
        intMask_reg <= laneLow2(wdata, byteenable[0]);
      end
      if (selGpio) begin
        gpioSel_reg <= laneLow2(wdata, byteenable[0]);
      end
    end
  end

  // ----------------------------------------
  // Trigger decode
  // ----------------------------------------
  // Reserved timer codes hold the servo off: triggers are ignored
  // until software has written the valid all-zero period.
  wire timerValid;
  wire trigWrite;
  wire [1:0] channelEnable;
  wire [1:0] measureStart;
  wire [1:0] loadStart;

  assign timerValid = (timer_reg == `TIMER_VALID);
  assign channelEnable = enable_reg & {timerValid, timerValid};
  // Trigger bits sit in lane 0; a high-byte-only write starts nothing
  assign trigWrite = writeTaken & selTrig & byteenable[0];
  // Measure wins when both triggers of a channel arrive in one write
  assign measureStart[0] = trigWrite & wdata[`BIT_MEAS_LEFT];
  assign measureStart[1] = trigWrite & wdata[`BIT_MEAS_RIGHT];
  assign loadStart[0] = trigWrite & wdata[`BIT_LOAD_LEFT];
  assign loadStart[1] = trigWrite & wdata[`BIT_LOAD_RIGHT];

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  wire [1:0] measureBusy;
  wire [1:0] loadBusy;
  wire [1:0] measureDone;
  wire [1:0] loadDone;
  wire [7:0] offsetLeft;
  wire [7:0] offsetRight;

  // Both channels share one period; each keeps its own state and count
  servo_channel #(
    .MEASURE_CYCLES(MEASURE_CYCLES),
    .LOAD_CYCLES(LOAD_CYCLES)
  ) leftChannel (
    .clk(clk),
    .srst(srst),
    .servoEnable(channelEnable[0]),
    .measureStart(measureStart[0]),
    .loadStart(loadStart[0]),
    .loadWord(loadWords_reg[7:0]),
    .measuredOffset(measuredOffsetLeft),
    .measureBusy(measureBusy[0]),
    .loadBusy(loadBusy[0]),
    .measureDone(measureDone[0]),
    .loadDone(loadDone[0]),
    .offsetWord(offsetLeft)
  );

  servo_channel #(
    .MEASURE_CYCLES(MEASURE_CYCLES),
    .LOAD_CYCLES(LOAD_CYCLES)
  ) rightChannel (
    .clk(clk),
    .srst(srst),
    .servoEnable(channelEnable[1]),
    .measureStart(measureStart[1]),
    .loadStart(loadStart[1]),
    .loadWord(loadWords_reg[15:8]),
    .measuredOffset(measuredOffsetRight),
    .measureBusy(measureBusy[1]),
    .loadBusy(loadBusy[1]),
    .measureDone(measureDone[1]),
    .loadDone(loadDone[1]),
    .offsetWord(offsetRight)
  );

  // Corrections come straight from the channel flip-flops
  assign leftHeadphoneCorrection = offsetLeft;
  assign rightHeadphoneCorrection = offsetRight;

  // ----------------------------------------
  // Completion and events
  // ----------------------------------------
  wire [1:0] correctionDone;
  reg [1:0] doneLast_reg;
  reg [1:0] intStatus_reg;
  wire [1:0] doneRise;
  wire [1:0] statusClear;

  assign correctionDone = measureDone | loadDone;
  // Edge, not level: a flag that stays set raises one event only
  assign doneRise = correctionDone & ~doneLast_reg;
  assign statusClear = (writeTaken & selStatus) ? laneLow2(wdata, byteenable[0]) : 2'h0;

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Set beats clear when an event and a clear land in one clock
  always @(posedge clk) begin
    if (srst) begin
      doneLast_reg <= 2'h0;
      intStatus_reg <= `RST_STATUS;
    end else begin
      doneLast_reg <= correctionDone;
      // events into interrupt, set beats clear
      intStatus_reg <= (intStatus_reg & ~statusClear) | doneRise;
    end
  end

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  // Registered so the pins never glitch on a decode change;
  // irq trails the status and mask by one clock, gpioDone the done flags and GPIO select.
  // interrupt and GPIO routing
  always @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
      gpioDone <= 2'h0;
    end else begin
      irq <= |(intStatus_reg & intMask_reg);
      gpioDone <= correctionDone & gpioSel_reg;
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Unmapped and reserved indices read as zero
  reg [15:0] readMux;

  always @* begin
    readMux = 16'h0000;
    if (selTrig) begin
      readMux[`BIT_ENA_LEFT] = enable_reg[0];
      readMux[`BIT_ENA_RIGHT] = enable_reg[1];
      readMux[`BIT_LOAD_LEFT] = loadBusy[0];
      readMux[`BIT_LOAD_RIGHT] = loadBusy[1];
      readMux[`BIT_MEAS_LEFT] = measureBusy[0];
      readMux[`BIT_MEAS_RIGHT] = measureBusy[1];
    end else if (selTimer) begin
      readMux[3:0] = timer_reg;
    end else if (selReadback) begin
      readMux[`POS_MEAS_DONE+1:`POS_MEAS_DONE] = measureDone;
      readMux[`POS_LOAD_DONE+1:`POS_LOAD_DONE] = loadDone;
      readMux[`POS_CORR_DONE+1:`POS_CORR_DONE] = correctionDone;
    end else if (selOffset) begin
      readMux[`POS_OFFSET_RIGHT+7:`POS_OFFSET_RIGHT] = offsetRight;
      readMux[`POS_OFFSET_LEFT+7:`POS_OFFSET_LEFT] = offsetLeft;
    end else if (selStatus) begin
      readMux[1:0] = intStatus_reg;
    end else if (selMask) begin
      readMux[1:0] = intMask_reg;
    end else if (selGpio) begin
      readMux[1:0] = gpioSel_reg;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      readdata <= 32'h00000000;
    end else if (read && !ack_reg) begin
      // Loaded on the first request cycle, so it stands at the answer
      readdata <= {16'h0000, readMux};
    end
  end

endmodule // headphone_dc_offset_servo

// ### design/servo_channel.v
`timescale 1ns/1ns
`include "servo_regs.vh"

module servo_channel #(
  parameter integer MEASURE_CYCLES = `MEASURE_CYCLES,
  parameter integer LOAD_CYCLES = `LOAD_CYCLES,
  parameter integer CNT_W = 24
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire servoEnable,
  input wire measureStart,
  input wire loadStart,
  input wire [7:0] loadWord,
  input wire [7:0] measuredOffset,
  // Status
  output wire measureBusy,
  output wire loadBusy,
  output reg measureDone,
  output reg loadDone,
  output reg [7:0] offsetWord
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_MEASURE = 2'd1;
  localparam [1:0] ST_LOAD = 2'd2;

  reg [1:0] state_reg;
  reg [CNT_W-1:0] count_reg;

  assign measureBusy = (state_reg == ST_MEASURE);
  assign loadBusy = (state_reg == ST_LOAD);

  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      count_reg <= {CNT_W{1'b0}};
      measureDone <= 1'b0;
      loadDone <= 1'b0;
      offsetWord <= `RST_OFFSET;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (servoEnable && measureStart) begin
            state_reg <= ST_MEASURE;
            count_reg <= MEASURE_CYCLES[CNT_W-1:0] - 1'b1;
            measureDone <= 1'b0;
          end else if (servoEnable && loadStart) begin
            state_reg <= ST_LOAD;
            count_reg <= LOAD_CYCLES[CNT_W-1:0] - 1'b1;
            loadDone <= 1'b0;
          end
        end
        ST_MEASURE: begin
          // Disabling the channel abandons the run without a done flag
          if (!servoEnable) begin
            state_reg <= ST_IDLE;
          end else if (count_reg == {CNT_W{1'b0}}) begin
            state_reg <= ST_IDLE;
            offsetWord <= measuredOffset;
            measureDone <= 1'b1;
          end else begin
            count_reg <= count_reg - 1'b1;
          end
        end
        ST_LOAD: begin
          if (!servoEnable) begin
            state_reg <= ST_IDLE;
          end else if (count_reg == {CNT_W{1'b0}}) begin
            state_reg <= ST_IDLE;
            offsetWord <= loadWord;
            loadDone <= 1'b1;
          end else begin
            count_reg <= count_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // servo_channel

// ### design/servo_regs.vh
`ifndef SERVO_REGS_VH
`define SERVO_REGS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_TRIG_ENA 10'h054
`define IDX_TIMER 10'h055
`define IDX_READBACK 10'h058
`define IDX_OFFSET 10'h059
`define IDX_INT_STATUS 10'h060
`define IDX_INT_MASK 10'h061
`define IDX_GPIO_SEL 10'h062

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_ENA_LEFT 0
`define BIT_ENA_RIGHT 1
`define BIT_LOAD_LEFT 2
`define BIT_LOAD_RIGHT 3
`define BIT_MEAS_LEFT 4
`define BIT_MEAS_RIGHT 5
`define POS_MEAS_DONE 0
`define POS_LOAD_DONE 4
`define POS_CORR_DONE 8
`define POS_OFFSET_LEFT 0
`define POS_OFFSET_RIGHT 8

// ----------------------------------------
// Reset values and the valid timer code
// ----------------------------------------
`define RST_TIMER 4'ha
`define TIMER_VALID 4'h0
`define RST_OFFSET 8'h00
`define RST_ENA 2'h0
`define RST_MASK 2'h0
`define RST_GPIO_SEL 2'h0
`define RST_STATUS 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 100
`define MEASURE_TIME_US 86000
`define LOAD_TIME_US 2000
`define MEASURE_CYCLES (`MEASURE_TIME_US * `CLK_MHZ)
`define LOAD_CYCLES (`LOAD_TIME_US * `CLK_MHZ)

`endif

// ### tb/headphone_dc_offset_servo_properties.sv
`timescale 1ns/1ns
`include "servo_regs.vh"
module servo_checker #(
  parameter integer MEASURE_CYCLES = 20,
  parameter integer LOAD_CYCLES = 5,
  parameter integer ADDR_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Bus
  input wire [ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Outputs
  input wire [7:0] leftHeadphoneCorrection,
  input wire [7:0] rightHeadphoneCorrection,
  input wire irq,
  input wire [1:0] gpioDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire [9:0] idx = address[11:2];
  wire rdAck = read && !waitrequest;
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_idle_ready: assert property (!(read || write) |-> !waitrequest)
    else $error("wait while idle");
  a_upper_zero: assert property (rdAck |-> readdata[31:16] == 16'h0000)
    else $error("upper read half set");
  a_timer_width: assert property (rdAck && idx == `IDX_TIMER |-> readdata[15:4] == 12'h000)
    else $error("timer stray bits");
  a_busy_excl: assert property (rdAck && idx == `IDX_TRIG_ENA |-> readdata[15:6] == 10'h000
    && !(readdata[2] && readdata[4]) && !(readdata[3] && readdata[5]))
    else $error("two runs on a channel");
  a_done_or: assert property (rdAck && idx == `IDX_READBACK |->
    readdata[9:8] == (readdata[1:0] | readdata[5:4]))
    else $error("combined flag wrong");
  a_offset_live: assert property (rdAck && idx == `IDX_OFFSET |->
    readdata[15:0] == {$past(rightHeadphoneCorrection), $past(leftHeadphoneCorrection)})
    else $error("offset read not live");
  a_gpio_done: assert property (rdAck && idx == `IDX_READBACK |->
    ($past(gpioDone) & ~readdata[9:8]) == 2'b00)
    else $error("gpio without done");
  a_reset_clear: assert property ($fell(srst) |-> !irq && gpioDone == 2'b00 &&
    leftHeadphoneCorrection == 8'h00 && rightHeadphoneCorrection == 8'h00)
    else $error("outputs not cleared");
  a_unmapped_zero: assert property (rdAck && (idx < 10'h054 || idx > 10'h062) |->
    readdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule // servo_checker

bind headphone_dc_offset_servo servo_checker #(.MEASURE_CYCLES(MEASURE_CYCLES),
  .LOAD_CYCLES(LOAD_CYCLES), .ADDR_W(ADDR_W)) servo_checker_i (.clk(clk), .srst(srst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .leftHeadphoneCorrection(leftHeadphoneCorrection),
  .rightHeadphoneCorrection(rightHeadphoneCorrection), .irq(irq), .gpioDone(gpioDone));

// ### tb/headphone_dc_offset_servo_test.sv
`timescale 1ns/1ns
`include "servo_regs.vh"
module headphone_dc_offset_servo_test;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [11:0] address = 12'h000;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [7:0] measuredOffsetLeft = 8'h00;
  reg [7:0] measuredOffsetRight = 8'h00;
  wire [31:0] readdata;
  wire waitrequest;
  wire [7:0] leftHeadphoneCorrection;
  wire [7:0] rightHeadphoneCorrection;
  wire irq;
  wire [1:0] gpioDone;
  integer seed = 32'ha834;
  integer miscompares = 0;
  integer tests_run = 0;
  integer i;
  reg [31:0] q;
  reg [1:0] mDone = 2'b00, lDone = 2'b00, stat = 2'b00;
  reg [7:0] corr [0:1];
  reg [15:0] loadW;

  always #5 clk = ~clk;

  // Short run lengths keep the simulation brief
  headphone_dc_offset_servo #(.MEASURE_CYCLES(30), .LOAD_CYCLES(12), .ADDR_W(12))
    headphone_dc_offset_servo_i (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h3), .readdata(readdata),
    .waitrequest(waitrequest), .measuredOffsetLeft(measuredOffsetLeft),
    .measuredOffsetRight(measuredOffsetRight),
    .leftHeadphoneCorrection(leftHeadphoneCorrection),
    .rightHeadphoneCorrection(rightHeadphoneCorrection), .irq(irq), .gpioDone(gpioDone));

  task end_of_test;
    begin
      $display("compares %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task xfer(input wr, input [9:0] idx, input [15:0] d);
    integer n;
    begin
      @(posedge clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= {16'h0000, d};
      n = 0;
      // Waitrequest and read data are sampled at the rising edge
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 40) begin
        @(posedge clk);
        n = n + 1;
      end
      if (waitrequest !== 1'b0) begin
        miscompares = miscompares + 1;
        end_of_test;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task rd(input [9:0] idx, input [31:0] exp, input string name);
    begin
      xfer(1'b0, idx, 16'h0000);
      chk(name, exp, q);
    end
  endtask

  function [31:0] rb;
    input dummy;
    rb = {22'h0, mDone | lDone, 2'b00, lDone, 2'b00, mDone};
  endfunction

  // ----------------------------------------
  // One correction run on one channel
  // ----------------------------------------
  task run(input c, input meas);
    integer n;
    reg was;
    reg [15:0] bitSel;
    begin
      bitSel = 16'h0001 << (meas ? 4 + c : 2 + c);
      if (meas) mDone[c] = 1'b0;
      else lDone[c] = 1'b0;
      was = mDone[c] | lDone[c];
      xfer(1'b1, `IDX_TRIG_ENA, 16'h0003 | bitSel);
      rd(`IDX_READBACK, rb(1'b0), "cleared flag");
      rd(`IDX_TRIG_ENA, {16'h0, 16'h0003 | bitSel}, "busy");
      n = 0;
      do begin
        xfer(1'b0, `IDX_TRIG_ENA, 16'h0000);
        n = n + 1;
      end while (q[5:2] !== 4'h0 && n < 30);
      if (q[5:2] !== 4'h0) begin
        miscompares = miscompares + 1;
        end_of_test;
      end
      if (meas) corr[c] = c ? measuredOffsetRight : measuredOffsetLeft;
      else corr[c] = c ? loadW[15:8] : loadW[7:0];
      if (meas) mDone[c] = 1'b1;
      else lDone[c] = 1'b1;
      if (!was) stat[c] = 1'b1;
      rd(`IDX_READBACK, rb(1'b0), "done flags");
      rd(`IDX_OFFSET, {16'h0, corr[1], corr[0]}, "offset");
      chk("correction", {corr[1], corr[0]}, {rightHeadphoneCorrection, leftHeadphoneCorrection});
    end
  endtask

  initial begin
    corr[0] = 8'h00;
    corr[1] = 8'h00;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(`IDX_TRIG_ENA, 32'h0, "enables");
    rd(`IDX_TIMER, 32'ha, "timer");
    rd(`IDX_OFFSET, 32'h0, "offset");
    rd(10'h100, 32'h0, "unmapped");
    xfer(1'b1, 10'h100, 16'hffff);
    xfer(1'b1, `IDX_READBACK, 16'hffff);
    rd(`IDX_READBACK, 32'h0, "readback");
    xfer(1'b1, `IDX_TIMER, 16'h0000);
    xfer(1'b1, `IDX_TRIG_ENA, 16'h0003);
    // Reserved timer code keeps the servo inert
    xfer(1'b1, `IDX_TIMER, 16'h0005);
    xfer(1'b1, `IDX_TRIG_ENA, 16'h003f);
    rd(`IDX_TRIG_ENA, 32'h3, "refused");
    xfer(1'b1, `IDX_TIMER, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      loadW = (i < 2) ? 16'h7f80 : $random(seed);
      // quiet input held through a run
      measuredOffsetLeft <= $random(seed);
      measuredOffsetRight <= $random(seed);
      xfer(1'b1, `IDX_OFFSET, loadW);
      run(i[0], (i < 2) ? 1'b0 : $random(seed));
    end
    // ----------------------------------------
    // Interrupt and pin outputs
    // ----------------------------------------
    rd(`IDX_INT_STATUS, {30'h0, stat}, "status");
    chk("irq masked", 32'h0, irq);
    xfer(1'b1, `IDX_INT_MASK, 16'h0001);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, irq);
    xfer(1'b1, `IDX_INT_STATUS, 16'h0001);
    rd(`IDX_INT_STATUS, 32'h2, "status");
    chk("irq", 32'h0, irq);
    xfer(1'b1, `IDX_INT_MASK, 16'h0003);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, irq);
    xfer(1'b1, `IDX_INT_STATUS, 16'h0002);
    rd(`IDX_INT_STATUS, 32'h0, "status");
    chk("irq", 32'h0, irq);
    xfer(1'b1, `IDX_GPIO_SEL, 16'h0002);
    repeat (2) @(negedge clk);
    chk("gpio", {mDone[1] | lDone[1], 1'b0}, gpioDone);
    end_of_test;
  end
endmodule // headphone_dc_offset_servo_test
